// ### bench/mrc_monitor.sv
// Checker on the receive-control ports: stream timing, cut lengths, mode.
// Bound onto mrc_rx_ctrl; sees its ports only.
`timescale 1ns/1ns
module mrc_monitor (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Stream and mode
	input wire mrc_pkg::mrc_byte_s rx_in,
	input wire mrc_pkg::mrc_byte_s rx_out,
	input wire mrc_pkg::mrc_cmd_s rx_command_word_a,
	input wire logic mac_full_duplex,
	input wire logic [1:0] mac_speed
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	// Last output byte of a frame
	sequence s_close;
		rx_out.valid && rx_out.last;
	endsequence
	a_gig_full: assert property (mac_speed == mrc_pkg::SPD_GIG |-> mac_full_duplex)
		else $error("half duplex at gigabit");
	a_close_cmd: assert property (s_close |-> rx_command_word_a.valid)
		else $error("frame end without command word");
	a_cmd_byte: assert property (rx_command_word_a.valid |-> $past(rx_in.valid))
		else $error("command word without a taken byte");
	a_out_byte: assert property (rx_out.valid |-> $past(rx_in.valid))
		else $error("output byte without input byte");
	a_cmd_pulse: assert property (rx_command_word_a.valid |=> !rx_command_word_a.valid)
		else $error("command word held");
	a_cap_len: assert property (rx_command_word_a.valid |-> rx_command_word_a.len <= 14'h2c01)
		else $error("length above watchdog cut");
	a_wdog_len: assert property (rx_command_word_a.wdog_timeout &&
		rx_command_word_a.valid |-> rx_command_word_a.len == 14'h2c01
		&& rx_command_word_a.long_frame)
		else $error("watchdog cut with wrong length");
	a_wdog_long: assert property (!rx_command_word_a.long_frame &&
		rx_command_word_a.valid |-> !rx_command_word_a.wdog_timeout)
		else $error("timeout flag on short frame");
endmodule : mrc_monitor
bind mrc_rx_ctrl mrc_monitor u_mrc_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst), .rx_in(rx_in),
	.rx_out(rx_out), .rx_command_word_a(rx_command_word_a), .mac_full_duplex(mac_full_duplex),
	.mac_speed(mac_speed));

// ### bench/mrc_phy_model.sv
// Line-side partner: sends frames byte by byte, fast or with gaps.
// Assumes the caller supplies whole frames.
`timescale 1ns/1ns
module mrc_phy_model (
	// Clock
	input wire logic clk_sys,
	// Byte stream toward the MAC
	output mrc_pkg::mrc_byte_s rx_in
);
	logic [7:0] last_byte = 8'h00;
	initial rx_in = '0;
	////////////////////////////////////////
	// Idle data is the inverse of the last byte, so stale data never matches
	task automatic send(input logic [7:0] f[$], input int gap);
		for (int i = 0; i < f.size(); i++) begin
			@(posedge clk_sys);
			rx_in <= '{valid: 1'b1, last: (i == f.size() - 1), data: f[i]};
			last_byte = f[i];
			repeat (gap) begin
				@(posedge clk_sys);
				rx_in <= '{valid: 1'b0, last: 1'b0, data: ~last_byte};
			end
		end
		@(posedge clk_sys);
		rx_in <= '{valid: 1'b0, last: 1'b0, data: ~last_byte};
	endtask : send
endmodule : mrc_phy_model

// ### bench/mrc_rx_ctrl_bench.sv
// Bench for the receive-control block: APB master, frames, config image.
// Assumes the partner model drives rx_in.
`timescale 1ns/1ns
module mrc_rx_ctrl_bench;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, irq, mac_full_duplex, err;
	logic img_load = 1'b0, ee_present = 1'b0, otp_programmed = 1'b0;
	logic usb_reset = 1'b0, soft_lite_reset = 1'b0, det_duplex = 1'b0;
	logic [1:0] det_speed = 2'h0, mac_speed;
	mrc_pkg::mrc_img_s ee_img = '0, otp_img = '0;
	mrc_pkg::mrc_byte_s rx_in, rx_out;
	mrc_pkg::mrc_cmd_s cw;
	logic [7:0] frm[$], exp_b[$];
	logic [31:0] exp_c[$];
	int bad_count = 0, n_tests = 0, seed = 32'h0a5e_01c2;
	int mx = 1518, watchdog_trunc_sel = 1, strip = 0, vlan_size_enforce = 0;
	int tbl[9][6] = '{'{1518, 1, 0, 0, 20, 0}, '{1518, 1, 1, 0, 12, 0}, '{16, 0, 0, 0, 25, 0},
		'{16, 0, 0, 1, 20, 1}, '{16, 0, 0, 1, 30, 2}, '{16, 0, 0, 0, 20, 1},
		'{16, 1, 0, 0, 11270, 0}, '{16, 0, 0, 1, 22, 1}, '{16, 1, 0, 0, 20, 0}};
	initial forever #10 clk_sys = ~clk_sys;
	mrc_rx_ctrl u_mrc_rx_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .img_load(img_load), .ee_present(ee_present),
		.ee_img(ee_img), .otp_programmed(otp_programmed), .otp_img(otp_img),
		.usb_reset(usb_reset), .soft_lite_reset(soft_lite_reset), .det_duplex(det_duplex),
		.det_speed(det_speed), .rx_in(rx_in), .rx_out(rx_out), .rx_command_word_a(cw),
		.mac_full_duplex(mac_full_duplex), .mac_speed(mac_speed), .irq(irq));
	mrc_phy_model u_mrc_phy_model (.clk_sys(clk_sys), .rx_in(rx_in));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic stop_test;
		$display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			stop_test();
		end
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] want);
		apb(1'b0, a, '0);
		chk(q, want);
	endtask : rd
	task automatic ck_irq(input logic want);
		@(negedge clk_sys);
		chk(irq, want);
	endtask : ck_irq
	// Settings change only with the receiver off
	task automatic setup(input int a, input int b, input int c, input int d);
		logic [31:0] v;
		// Receiver goes off with the old settings before any of them moves
		v = {2'b00, 14'(mx), 10'h000, 1'(watchdog_trunc_sel), 1'(strip), 1'b0, 1'(vlan_size_enforce), 2'b00};
		apb(1'b1, mrc_pkg::OFF_RX_CTRL, v);
		mx = a;
		watchdog_trunc_sel = b;
		strip = c;
		vlan_size_enforce = d;
		v = {2'b00, 14'(a), 10'h000, 1'(b), 1'(c), 1'b0, 1'(d), 2'b00};
		apb(1'b1, mrc_pkg::OFF_RX_CTRL, v);
		apb(1'b1, mrc_pkg::OFF_RX_CTRL, v | 32'h0000_0001);
	endtask : setup
	task automatic drain;
		int k;
		k = 0;
		while (exp_c.size() != 0 && k < 60) begin
			@(posedge clk_sys);
			k++;
		end
		repeat (4) @(posedge clk_sys);
		if (exp_c.size() != 0 || exp_b.size() != 0) begin
			bad_count++;
			stop_test();
		end
	endtask : drain
	// Expected bytes and command word noted before the frame is sent
	task automatic run(input int n, input int tags, input int gap);
		int lim, cut, m;
		frm.delete();
		for (int i = 0; i < n; i++) frm.push_back(8'($random(seed)));
		for (int t = 0; t < tags; t++) begin
			frm[12 + 4 * t] = 8'h81;
			frm[13 + 4 * t] = 8'h00;
		end
		lim = mx + (vlan_size_enforce != 0 ? 4 * tags : 0);
		cut = (n <= lim) ? 0 : (watchdog_trunc_sel != 0 ? 11265 : lim + 1);
		if (n <= cut) cut = 0;
		m = (cut != 0) ? cut : (strip != 0 ? n - 4 : n);
		for (int i = 0; i < m; i++) exp_b.push_back(frm[i]);
		exp_c.push_back({16'h0000, 14'(m), 1'(n > lim), 1'(cut == 11265)});
		u_mrc_phy_model.send(frm, gap);
		drain();
	endtask : run
	////////////////////////////////////////
	// Oldest note is taken whenever a byte or command word shows up
	always @(posedge clk_sys) begin
		if (rx_out.valid === 1'b1) begin
			chk(rx_out.data, exp_b.size() != 0 ? exp_b.pop_front() : 8'hxx);
		end
		if (cw.valid === 1'b1) begin
			chk({cw.len, cw.long_frame, cw.wdog_timeout},
				exp_c.size() != 0 ? exp_c.pop_front() : 'x);
			chk({rx_out.valid, rx_out.last}, 2'b11);
		end
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(mrc_pkg::OFF_RX_CTRL, 32'h05ee_0020);
		rd(mrc_pkg::OFF_MAC_CFG, 32'h0000_2000);
		rd(12'h200, 32'h0000_0000);
		chk(err, 1'b1);
		for (int i = 0; i < 9; i++) begin
			setup(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
			run(tbl[i][4], tbl[i][5], i % 2);
		end
		setup(1518, 1, 0, 0);
		apb(1'b1, mrc_pkg::OFF_INT_STS, 32'h0000_0007);
		apb(1'b1, mrc_pkg::OFF_RX_CTRL, 32'h05ee_0023);
		rd(mrc_pkg::OFF_RX_CTRL, 32'h05ee_0021);
		rd(mrc_pkg::OFF_INT_STS, 32'h0000_0000);
		fork
			run(40, 0, 0);
			begin
				repeat (12) @(posedge clk_sys);
				apb(1'b1, mrc_pkg::OFF_RX_CTRL, 32'h05ee_0020);
			end
		join
		rd(mrc_pkg::OFF_RX_CTRL, 32'h05ee_0022);
		rd(mrc_pkg::OFF_INT_STS, 32'h0000_0001);
		ck_irq(1'b0);
		apb(1'b1, mrc_pkg::OFF_INT_MASK, 32'h0000_0001);
		ck_irq(1'b1);
		apb(1'b1, mrc_pkg::OFF_INT_STS, 32'h0000_0001);
		ck_irq(1'b0);
		frm = '{8'h5a, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
		u_mrc_phy_model.send(frm, 0);
		drain();
		det_speed <= 2'($random(seed));
		apb(1'b1, mrc_pkg::OFF_MAC_CFG, 32'h0000_0004);
		ck_irq(1'b0);
		chk({mac_full_duplex, mac_speed}, 32'h0000_0006);
		apb(1'b1, mrc_pkg::OFF_MAC_CFG, 32'h0000_000a);
		ck_irq(1'b0);
		chk({mac_full_duplex, mac_speed}, 32'h0000_0005);
		apb(1'b1, mrc_pkg::OFF_MAC_CFG, 32'h0000_1004);
		rd(mrc_pkg::OFF_MAC_CFG, {19'h0, 1'b1, 9'h000, det_speed, 1'b0});
		chk({mac_full_duplex, mac_speed}, {det_speed == 2'h2, det_speed});
		// Image from the EEPROM, then from OTP with both auto bits set
		ee_present <= 1'b1;
		ee_img <= 5'($random(seed)) & 5'h07;
		@(posedge clk_sys) img_load <= 1'b1;
		@(posedge clk_sys) img_load <= 1'b0;
		apb(1'b1, mrc_pkg::OFF_MAC_CFG, 32'h0000_0000);
		@(posedge clk_sys) usb_reset <= 1'b1;
		@(posedge clk_sys) usb_reset <= 1'b0;
		rd(mrc_pkg::OFF_MAC_CFG, {28'h0, ee_img[2:0], 1'b0});
		ee_present <= 1'b0;
		otp_programmed <= 1'b1;
		otp_img <= 5'h18;
		det_duplex <= 1'b1;
		@(posedge clk_sys) img_load <= 1'b1;
		@(posedge clk_sys) img_load <= 1'b0;
		apb(1'b1, mrc_pkg::OFF_MAC_CFG, 32'h0000_0000);
		@(posedge clk_sys) soft_lite_reset <= 1'b1;
		@(posedge clk_sys) soft_lite_reset <= 1'b0;
		rd(mrc_pkg::OFF_MAC_CFG, {18'h0, 2'h3, 8'h00, 1'b1, det_speed, 1'b0});
		stop_test();
	end
endmodule : mrc_rx_ctrl_bench

// ### verilog/mrc_pkg.sv
// Package for the MAC receive-control block: register map, field layout,
// reset values, limits and the packed carriers shared by the design.
// Assumes a 12-bit APB byte address with one 32-bit register per word.
package mrc_pkg;

	// Register byte offsets
	localparam logic [11:0] OFF_MAC_CFG = 12'h0100;
	localparam logic [11:0] OFF_RX_CTRL = 12'h0104;
	localparam logic [11:0] OFF_INT_STS = 12'h0140;
	localparam logic [11:0] OFF_INT_MASK = 12'h0144;

	// receive_control fields
	localparam int RX_MAX_HI = 29;
	localparam int RX_MAX_LO = 16;
	localparam int RX_WTL_BIT = 5;
	localparam int RX_STRIP_BIT = 4;
	localparam int RX_FSE_BIT = 2;
	localparam int RX_DIS_BIT = 1;
	localparam int RX_EN_BIT = 0;

	// MAC configuration fields
	localparam int CFG_AUTO_DPX_BIT = 13;
	localparam int CFG_AUTO_SPD_BIT = 12;
	localparam int CFG_DPX_BIT = 3;
	localparam int CFG_SPD_HI = 2;
	localparam int CFG_SPD_LO = 1;

	// Interrupt status / mask fields
	localparam int IRQ_RXD_BIT = 0;
	localparam int IRQ_LONG_BIT = 1;
	localparam int IRQ_RWT_BIT = 2;
	localparam int IRQ_W = 3;

	// Reset values and limits
	localparam logic [13:0] MAX_SIZE_RST = 14'h05ee;
	localparam logic WTL_RST = 1'b1;
	localparam logic [14:0] WDOG_CUT = 15'h2c01;
	localparam logic [13:0] FCS_BYTES = 14'h0004;
	localparam logic [14:0] VLAN_STEP = 15'h0004;
	localparam logic [7:0] TPID_HI = 8'h81;
	localparam logic [7:0] TPID_LO = 8'h00;
	localparam logic [13:0] TAG1_POS = 14'h000e;
	localparam logic [13:0] TAG2_POS = 14'h0012;
	localparam logic [1:0] SPD_GIG = 2'h2;

	// Configuration image fields
	typedef struct packed {
		logic auto_dpx;
		logic auto_spd;
		logic duplex_select;
		logic [1:0] speed;
	} mrc_img_s;

	localparam mrc_img_s IMG_DEFAULT = '{auto_dpx: 1'b1, auto_spd: 1'b0, duplex_select: 1'b0,
		speed: 2'h0};

	// One byte of a frame
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} mrc_byte_s;

	// Receive command word toward the FIFO controller
	typedef struct packed {
		logic valid;
		logic [13:0] len;
		logic long_frame;
		logic wdog_timeout;
	} mrc_cmd_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RECV = 2'b01,
		ST_DROP = 2'b10
	} mrc_state_e;

endpackage : mrc_pkg

// ### verilog/mrc_rx_ctrl.sv
// MAC receive control: enable and graceful stop, length limits, watchdog
// truncation, FCS stripping and the duplex/speed configuration fields.
// Assumes byte stream input synchronous to clk_sys, one byte per valid.
`timescale 1ns/1ns

// Function
// - Flag frames longer than programmed maximum
// - Watchdog truncates frames beyond 11264 bytes
// - Select 0 cuts at max plus one
// - Select 1 cuts at 11265, flags timeout
// - Strip last four bytes when enabled
// - Without VLAN enforcement, plain maximum applies
// - VLAN enforcement adds 4 per tag
// - Receive only while enable bit set
// - Finish current frame before disabling receiver
// - Disabled flag set on shutdown, write-clear
// - Auto duplex defaults from image, restored
// - Auto speed defaults from image, restored
// - Duplex and speed default from image
// - Duplex select writable only without auto
// - Speed writable only without auto detect
// - No half duplex at gigabit speed; the read-back duplex bit is not forced
module mrc_rx_ctrl (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Configuration image and soft resets
	input wire logic img_load,
	input wire logic ee_present,
	input wire mrc_pkg::mrc_img_s ee_img,
	input wire logic otp_programmed,
	input wire mrc_pkg::mrc_img_s otp_img,
	input wire logic usb_reset,
	input wire logic soft_lite_reset,
	// Detected link mode
	input wire logic det_duplex,
	input wire logic [1:0] det_speed,
	// Frame stream in and out
	input wire mrc_pkg::mrc_byte_s rx_in,
	output mrc_pkg::mrc_byte_s rx_out,
	output mrc_pkg::mrc_cmd_s rx_command_word_a,
	// Effective mode and interrupt
	output logic mac_full_duplex,
	output logic [1:0] mac_speed,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Sticky bits: hardware set beats a same-cycle software clear
	function automatic logic [mrc_pkg::IRQ_W-1:0] mrc_w1c(
		input logic [mrc_pkg::IRQ_W-1:0] cur,
		input logic [mrc_pkg::IRQ_W-1:0] set,
		input logic [mrc_pkg::IRQ_W-1:0] clr);
		mrc_w1c = (cur & ~clr) | set;
	endfunction : mrc_w1c

	////////////////////////////////////////////////////////////////////////
	// Registers and bus decode

	logic [13:0] max_size_reg;
	logic wtl_reg;
	logic strip_reg;
	logic fse_reg;
	logic rxd_reg;
	logic rx_enable_bit;
	logic stop_pend_reg;
	mrc_pkg::mrc_img_s img_reg;
	mrc_pkg::mrc_img_s cfg_reg;
	logic [mrc_pkg::IRQ_W-1:0] sts_reg;
	logic [mrc_pkg::IRQ_W-1:0] mask_reg;
	wire logic [mrc_pkg::IRQ_W-1:0] evt;
	mrc_pkg::mrc_state_e state_reg;
	mrc_pkg::mrc_state_e state_next;

	logic wr;
	logic rd_setup;
	logic hit;
	logic sel_rx;
	logic sel_cfg;
	logic sel_sts;
	logic sel_mask;
	logic restore;
	logic dpx_eff;
	logic [1:0] spd_eff;

	// Zero-wait slave; read data latched in setup so it is a flop at access
	assign sel_rx = paddr == mrc_pkg::OFF_RX_CTRL;
	assign sel_cfg = paddr == mrc_pkg::OFF_MAC_CFG;
	assign sel_sts = paddr == mrc_pkg::OFF_INT_STS;
	assign sel_mask = paddr == mrc_pkg::OFF_INT_MASK;
	assign hit = sel_rx | sel_cfg | sel_sts | sel_mask;
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign restore = usb_reset | soft_lite_reset;

	// Detected values take over when auto detection is on
	assign dpx_eff = cfg_reg.auto_dpx ? det_duplex : cfg_reg.duplex_select;
	assign spd_eff = cfg_reg.auto_spd ? det_speed : cfg_reg.speed;
	assign mac_speed = spd_eff;
	assign mac_full_duplex = dpx_eff | (spd_eff == mrc_pkg::SPD_GIG);

	// Read mux
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= 32'h0000_0000;
			if (sel_rx) begin
				prdata[mrc_pkg::RX_MAX_HI:mrc_pkg::RX_MAX_LO] <= max_size_reg;
				prdata[mrc_pkg::RX_WTL_BIT] <= wtl_reg;
				prdata[mrc_pkg::RX_STRIP_BIT] <= strip_reg;
				prdata[mrc_pkg::RX_FSE_BIT] <= fse_reg;
				prdata[mrc_pkg::RX_DIS_BIT] <= rxd_reg;
				prdata[mrc_pkg::RX_EN_BIT] <= rx_enable_bit;
			end
			if (sel_cfg) begin
				prdata[mrc_pkg::CFG_AUTO_DPX_BIT] <= cfg_reg.auto_dpx;
				prdata[mrc_pkg::CFG_AUTO_SPD_BIT] <= cfg_reg.auto_spd;
				prdata[mrc_pkg::CFG_DPX_BIT] <= dpx_eff;
				prdata[mrc_pkg::CFG_SPD_HI:mrc_pkg::CFG_SPD_LO] <= spd_eff;
			end
			if (sel_sts) begin
				prdata[mrc_pkg::IRQ_W-1:0] <= sts_reg;
			end
			if (sel_mask) begin
				prdata[mrc_pkg::IRQ_W-1:0] <= mask_reg;
			end
		end
	end

	// Receive settings; kept stable by software while enabled
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			max_size_reg <= mrc_pkg::MAX_SIZE_RST;
			wtl_reg <= mrc_pkg::WTL_RST;
			strip_reg <= 1'b0;
			fse_reg <= 1'b0;
			rx_enable_bit <= 1'b0;
		end else if (wr && sel_rx) begin
			max_size_reg <= pwdata[mrc_pkg::RX_MAX_HI:mrc_pkg::RX_MAX_LO];
			wtl_reg <= pwdata[mrc_pkg::RX_WTL_BIT];
			strip_reg <= pwdata[mrc_pkg::RX_STRIP_BIT];
			fse_reg <= pwdata[mrc_pkg::RX_FSE_BIT];
			rx_enable_bit <= pwdata[mrc_pkg::RX_EN_BIT];
		end
	end

	// Graceful stop: only a 1-to-0 enable change arms it, old enable seen here
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stop_pend_reg <= 1'b0;
		end else if (wr && sel_rx && pwdata[mrc_pkg::RX_EN_BIT]) begin
			stop_pend_reg <= 1'b0;
		end else if (wr && sel_rx && rx_enable_bit) begin
			stop_pend_reg <= 1'b1;
		end else if (evt[mrc_pkg::IRQ_RXD_BIT]) begin
			stop_pend_reg <= 1'b0;
		end
	end

	// Shutdown completes once no frame is being taken
	assign evt[mrc_pkg::IRQ_RXD_BIT] = stop_pend_reg & ~rx_enable_bit
		& (state_reg != mrc_pkg::ST_RECV);

	// Disabled flag, write one to clear, set wins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rxd_reg <= 1'b0;
		end else begin
			rxd_reg <= evt[mrc_pkg::IRQ_RXD_BIT]
				| (rxd_reg & ~(wr & sel_rx & pwdata[mrc_pkg::RX_DIS_BIT]));
		end
	end

	// Loaded image: EEPROM first, then OTP, else fixed fallback
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			img_reg <= mrc_pkg::IMG_DEFAULT;
		end else if (img_load) begin
			if (ee_present) begin
				img_reg <= ee_img;
			end else if (otp_programmed) begin
				img_reg <= otp_img;
			end else begin
				img_reg <= mrc_pkg::IMG_DEFAULT;
			end
		end
	end

	// Configuration fields; soft resets restore the image
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_reg <= mrc_pkg::IMG_DEFAULT;
		end else if (restore) begin
			cfg_reg <= img_reg;
		end else if (img_load) begin
			cfg_reg <= ee_present ? ee_img : (otp_programmed ? otp_img : mrc_pkg::IMG_DEFAULT);
		end else if (wr && sel_cfg) begin
			cfg_reg.auto_dpx <= pwdata[mrc_pkg::CFG_AUTO_DPX_BIT];
			cfg_reg.auto_spd <= pwdata[mrc_pkg::CFG_AUTO_SPD_BIT];
			if (!cfg_reg.auto_dpx) begin
				cfg_reg.duplex_select <= pwdata[mrc_pkg::CFG_DPX_BIT];
			end
			if (!cfg_reg.auto_spd) begin
				cfg_reg.speed <= pwdata[mrc_pkg::CFG_SPD_HI:mrc_pkg::CFG_SPD_LO];
			end
		end
	end

	// Interrupt status and mask
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sts_reg <= '0;
			mask_reg <= '0;
		end else begin
			sts_reg <= mrc_w1c(sts_reg, evt,
				(wr && sel_sts) ? pwdata[mrc_pkg::IRQ_W-1:0] : '0);
			if (wr && sel_mask) begin
				mask_reg <= pwdata[mrc_pkg::IRQ_W-1:0];
			end
		end
	end

	assign irq = |(sts_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////
	// Frame datapath

	logic [13:0] cnt_reg;
	logic [1:0] tags_reg;
	logic [7:0] prev_reg;
	logic [7:0] hold_reg [0:3];
	logic start;
	logic take;
	logic fin;
	logic trunc_now;
	logic is_long;
	logic [13:0] cnt_n;
	logic [14:0] lim;
	logic [14:0] cut;
	logic [13:0] len_n;

	// Byte position includes DA through FCS
	always_comb begin
		start = (state_reg == mrc_pkg::ST_IDLE) & rx_in.valid & rx_enable_bit;
		take = start | ((state_reg == mrc_pkg::ST_RECV) & rx_in.valid);
		cnt_n = start ? 14'h0001 : 14'(cnt_reg + 14'h0001);
		lim = {1'b0, max_size_reg};
		if (fse_reg) begin
			lim = 15'(lim + 15'(tags_reg) * mrc_pkg::VLAN_STEP);
		end
		if (wtl_reg || (15'(lim + 15'h0001) > mrc_pkg::WDOG_CUT)) begin
			cut = mrc_pkg::WDOG_CUT;
		end else begin
			cut = 15'(lim + 15'h0001);
		end
		trunc_now = take & ({1'b0, cnt_n} == cut);
		fin = take & (rx_in.last | trunc_now);
		is_long = trunc_now | ({1'b0, cnt_n} > lim);
		if (trunc_now) begin
			len_n = cut[13:0];
		end else if (strip_reg) begin
			len_n = (cnt_n > mrc_pkg::FCS_BYTES) ? 14'(cnt_n - mrc_pkg::FCS_BYTES) : 14'h0000;
		end else begin
			len_n = cnt_n;
		end
	end

	assign evt[mrc_pkg::IRQ_LONG_BIT] = fin & is_long;
	assign evt[mrc_pkg::IRQ_RWT_BIT] = fin & trunc_now & (cut == mrc_pkg::WDOG_CUT);

	// Frame state: disabled frames and truncated tails are dropped
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			mrc_pkg::ST_IDLE: begin
				if (rx_in.valid && !rx_in.last) begin
					state_next = rx_enable_bit ? mrc_pkg::ST_RECV : mrc_pkg::ST_DROP;
				end
			end
			mrc_pkg::ST_RECV: begin
				if (fin) begin
					state_next = rx_in.last ? mrc_pkg::ST_IDLE : mrc_pkg::ST_DROP;
				end
			end
			mrc_pkg::ST_DROP: begin
				if (rx_in.valid && rx_in.last) begin
					state_next = mrc_pkg::ST_IDLE;
				end
			end
			default: state_next = mrc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= mrc_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Length counter and VLAN tag detection
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= 14'h0000;
			tags_reg <= 2'h0;
			prev_reg <= 8'h00;
		end else if (take) begin
			cnt_reg <= cnt_n;
			prev_reg <= rx_in.data;
			if (start) begin
				tags_reg <= 2'h0;
			end else if (prev_reg == mrc_pkg::TPID_HI && rx_in.data == mrc_pkg::TPID_LO) begin
				if (cnt_n == mrc_pkg::TAG1_POS) begin
					tags_reg <= 2'h1;
				end else if (cnt_n == mrc_pkg::TAG2_POS && tags_reg == 2'h1) begin
					tags_reg <= 2'h2;
				end
			end
		end
	end

	// Four-byte delay line; holding the tail lets the FCS be dropped
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				hold_reg[i] <= 8'h00;
			end
		end else if (take) begin
			hold_reg[0] <= rx_in.data;
			for (int i = 1; i < 4; i++) begin
				hold_reg[i] <= hold_reg[i-1];
			end
		end
	end

	// Output bytes and command word
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_out <= '0;
			rx_command_word_a <= '0;
		end else begin
			rx_out.valid <= 1'b0;
			rx_out.last <= 1'b0;
			if (take && strip_reg) begin
				rx_out.valid <= cnt_n > mrc_pkg::FCS_BYTES;
				rx_out.last <= fin;
				rx_out.data <= hold_reg[3];
			end else if (take) begin
				rx_out.valid <= 1'b1;
				rx_out.last <= fin;
				rx_out.data <= rx_in.data;
			end
			rx_command_word_a.valid <= fin;
			if (fin) begin
				rx_command_word_a.len <= len_n;
				rx_command_word_a.long_frame <= is_long;
				rx_command_word_a.wdog_timeout <= evt[mrc_pkg::IRQ_RWT_BIT];
			end
		end
	end

endmodule : mrc_rx_ctrl
